// *** hw/dei_pkg.sv ***
// constants shared by the dual encoder interrupt and clock-mode block
package dei_pkg;
    // ====================================================================
    // register byte offsets
    localparam logic [7:0]  OFS_INT        = 8'h00;
    localparam logic [7:0]  OFS_CLK        = 8'h04;
    localparam logic [7:0]  OFS_MODE       = 8'h08;
    localparam logic [7:0]  OFS_COUNT_A    = 8'h0c;
    localparam logic [7:0]  OFS_COUNT_B    = 8'h10;
    // ====================================================================
    // field positions of the interrupt register
    localparam int          INT_FLAG_LSB   = 8;
    localparam int          INT_ALLOW_LSB  = 0;
    localparam int          EVT_A_POS      = 0;
    localparam int          EVT_A_NEG      = 1;
    localparam int          EVT_B_POS      = 2;
    localparam int          EVT_B_NEG      = 3;
    // ====================================================================
    // field positions of the mode register
    localparam int          MODE_MASK_LSB  = 8;
    localparam int          MODE_COMPL     = 5;
    localparam int          MODE_GLITCH    = 4;
    localparam int          MODE_CASCADE   = 3;
    localparam int          MODE_INDEX     = 2;
    localparam int          MODE_HOLD      = 1;
    localparam int          MODE_ACTIVE    = 0;
    localparam logic [15:0] MODE_WR_MASK   = 16'hff3f;
    // ====================================================================
    // reset values
    localparam logic [3:0]  RST_FLAGS      = 4'h0;
    localparam logic [3:0]  RST_ALLOW      = 4'h0;
    localparam logic [3:0]  RST_CLK_SEL    = 4'h0;
    localparam logic [15:0] RST_MODE       = 16'h0000;
    localparam logic [15:0] RST_COUNT      = 16'h0000;
    // ====================================================================
    // sample clock select codes
    localparam logic [3:0]  SEL_BASE_25M   = 4'h0;
    localparam logic [3:0]  SEL_RESERVED   = 4'h1;
    localparam int          SEL_TC_LSB     = 2;
    localparam int          SEL_PROG_LSB   = 8;
    localparam int          SEL_STRB_LSB   = 12;
    localparam int          SEL_NSTRB_LSB  = 14;
    // ====================================================================
    // timing
    localparam int          SYS_CLK_HZ     = 100_000_000;
    localparam int          BASE_TICK_HZ   = 25_000_000;
    localparam int          BASE_TICK_DIV  = SYS_CLK_HZ / BASE_TICK_HZ;
    localparam int          GLITCH_SAMPLES = 4;
    localparam logic [15:0] COUNT_MAX      = 16'hffff;
    localparam logic [15:0] COUNT_MIN      = 16'h0000;
endpackage : dei_pkg

// *** hw/dei_chan_if.sv ***
// carrier between the top level and one encoder channel decoder
`timescale 1ns/1ps
`default_nettype none
interface dei_chan_if;
    logic       tick;        // sample clock tick, one cycle
    logic [1:0] pos_in;      // {b+, a+} raw pins
    logic [1:0] neg_in;      // {b-, a-} raw pins
    logic [7:0] transition_block_mask;
    logic       complementary_input_select;
    logic       glitch_on;
    logic       step_up;     // one-cycle count up
    logic       step_down;   // one-cycle count down

    modport top  (output tick, pos_in, neg_in, transition_block_mask,
                  complementary_input_select, glitch_on,
                  input step_up, step_down);
    modport chan (input tick, pos_in, neg_in, transition_block_mask,
                  complementary_input_select, glitch_on,
                  output step_up, step_down);
endinterface : dei_chan_if
`default_nettype wire

// *** hw/dei_channel.sv ***
// one quadrature channel: pin sync, pair check, glitch filter, step decode
`timescale 1ns/1ps
`default_nettype none
module dei_channel (
    // clock and reset
    input  wire logic  hclk,
    input  wire logic  hresetn,
    // channel carrier
    dei_chan_if.chan   ch
);
    // ====================================================================
    // pin synchronisers: {b-, a-, b+, a+}
    logic [3:0] s1, s2, s3, lvl;
    logic [3:0] next_lvl;
    logic [1:0] raw, samp, acc, prev;
    logic [1:0] next_samp, next_acc;
    logic [1:0][2:0] cnt, next_cnt;

    // a level counts once stages two and three agree
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_lvl[i] = (s2[i] == s3[i]) ? s3[i] : lvl[i];
        end
    end

    // pair check: in complementary mode a line moves only if + and - differ
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (!ch.complementary_input_select) begin
                raw[i] = lvl[i];
            end else if (lvl[i] != lvl[i+2]) begin
                raw[i] = lvl[i];
            end else begin
                raw[i] = samp[i];
            end
        end
    end

    // ====================================================================
    // glitch filter, counted in sample ticks, one lane per line
    always_comb begin
        next_samp = samp;
        next_cnt  = cnt;
        next_acc  = acc;
        for (int i = 0; i < 2; i++) begin
            if (ch.tick) begin
                next_samp[i] = raw[i];
                if (raw[i] != samp[i]) begin
                    next_cnt[i] = 3'h1;
                end else if (cnt[i] < 3'(dei_pkg::GLITCH_SAMPLES)) begin
                    next_cnt[i] = cnt[i] + 3'h1;
                end
                if (!ch.glitch_on) begin
                    next_acc[i] = raw[i];
                end else if (next_cnt[i] == 3'(dei_pkg::GLITCH_SAMPLES)) begin
                    next_acc[i] = raw[i];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1   <= 4'h0;
            s2   <= 4'h0;
            s3   <= 4'h0;
            lvl  <= 4'h0;
            samp <= 2'h0;
            cnt  <= '0;
            acc  <= 2'h0;
            prev <= 2'h0;
        end else begin
            s1   <= {ch.neg_in, ch.pos_in};
            s2   <= s1;
            s3   <= s2;
            lvl  <= next_lvl;
            samp <= next_samp;
            cnt  <= next_cnt;
            acc  <= next_acc;
            prev <= acc;
        end
    end

    // ====================================================================
    // step decode from previous and current {b,a}; a set mask bit blocks it
    always_comb begin
        ch.step_up   = 1'b0;
        ch.step_down = 1'b0;
        case ({prev, acc})
            4'b00_10: ch.step_down = ~ch.transition_block_mask[7];
            4'b10_11: ch.step_down = ~ch.transition_block_mask[6];
            4'b11_01: ch.step_down = ~ch.transition_block_mask[5];
            4'b01_00: ch.step_down = ~ch.transition_block_mask[4];
            4'b10_00: ch.step_up   = ~ch.transition_block_mask[3];
            4'b11_10: ch.step_up   = ~ch.transition_block_mask[2];
            4'b01_11: ch.step_up   = ~ch.transition_block_mask[1];
            4'b00_01: ch.step_up   = ~ch.transition_block_mask[0];
            default: begin
                ch.step_up   = 1'b0;   // no move, or a skipped state
                ch.step_down = 1'b0;
            end
        endcase
    end
endmodule : dei_channel
`default_nettype wire

// *** hw/dei_top.sv ***
// dual encoder: interrupt, sample clock select and mode registers on ahb-lite
//
// How it works
// - channel B counter wrapping down from 0x0000 to 0xFFFF sets B underflow flag.
// - channel B counter wrapping up from 0xFFFF to 0x0000 sets B overflow flag.
// - channel A counter wrapping down from 0x0000 to 0xFFFF sets A underflow flag.
// - channel A counter wrapping up from 0xFFFF to 0x0000 sets A overflow flag.
// - flags stay set until software writes one there; all reset to zero.
// - four enable bits let each rollover raise the interrupt; reset to zero.
// - flags sit at bits 11..8, enables at 3..0; other bits read zero.
// - four-bit sample clock select in bits 3..0, resets zero, upper bits zero.
// - select codes: 25 MHz, reserved, six timer counts, four clocks, strobes.
// - mode: mask 15..8, complementary 5, glitch 4, cascade 3, index 2, hold 1, on 0.
// - a mask bit of one stops its transition from moving the counter.
// - complementary mode accepts a change only while + and - inputs differ.
// - glitch filter accepts a level held for four sample clock cycles.
// - cascade joins both 16-bit counters into one 32-bit counter.
`timescale 1ns/1ps
`default_nettype none
module dei_top (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // encoder pins, {b, a} per vector
    input  wire logic [1:0]  chan_a_pos_in,
    input  wire logic [1:0]  chan_a_neg_in,
    input  wire logic [1:0]  chan_b_pos_in,
    input  wire logic [1:0]  chan_b_neg_in,
    // sample clock sources
    input  wire logic [5:0]  timer_tc,
    input  wire logic [3:0]  prog_clk,
    input  wire logic [1:0]  strobe,
    // interrupt
    output logic             irq
);
    // ====================================================================
    // declarations
    typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_WDONE} dei_bus_e;
    dei_bus_e    bus_state, next_bus_state;
    logic [7:0]  wr_addr, next_wr_addr;
    logic [31:0] next_hrdata;
    logic        addr_ok;
    logic [3:0]  flags, next_flags;
    logic [3:0]  allow, next_allow;
    logic [3:0]  clk_sel, next_clk_sel;
    logic [15:0] mode, next_mode;
    logic [15:0] count_a, count_b, next_count_a, next_count_b;
    logic [3:0]  rollover;
    logic        wr_int, wr_clk, wr_mode;
    logic [11:0] src_s1, src_s2, src_s3, src_lvl, next_src_lvl;
    logic [15:0] src_tick;
    logic [1:0]  div, next_div;
    logic        tick;
    logic        run, up_a, dn_a, up_b, dn_b;

    dei_chan_if  if_a ();
    dei_chan_if  if_b ();

    // ====================================================================
    // ahb-lite decode; a write takes one wait state so that a read right
    // behind it already sees the new value
    assign addr_ok   = hsel && hready && htrans[1];
    assign hreadyout = (bus_state != BUS_WRITE);
    assign hresp     = 1'b0;

    always_comb begin
        next_bus_state = bus_state;
        next_wr_addr   = wr_addr;
        case (bus_state)
            BUS_IDLE, BUS_WDONE: begin
                next_bus_state = BUS_IDLE;
                if (addr_ok && hwrite) begin
                    next_bus_state = BUS_WRITE;
                    next_wr_addr   = haddr;
                end
            end
            BUS_WRITE: next_bus_state = BUS_WDONE;
            default:   next_bus_state = BUS_IDLE;
        endcase
    end

    assign wr_int  = (bus_state == BUS_WRITE) && (wr_addr == dei_pkg::OFS_INT);
    assign wr_clk  = (bus_state == BUS_WRITE) && (wr_addr == dei_pkg::OFS_CLK);
    assign wr_mode = (bus_state == BUS_WRITE) && (wr_addr == dei_pkg::OFS_MODE);

    // read data captured at the address phase; unmapped reads give zero
    always_comb begin
        next_hrdata = hrdata;
        if (addr_ok && !hwrite) begin
            case (haddr)
                dei_pkg::OFS_INT:     next_hrdata = {20'h0, flags, 4'h0, allow};
                dei_pkg::OFS_CLK:     next_hrdata = {28'h0, clk_sel};
                dei_pkg::OFS_MODE:    next_hrdata = {16'h0, mode};
                dei_pkg::OFS_COUNT_A: next_hrdata = {16'h0, count_a};
                dei_pkg::OFS_COUNT_B: next_hrdata = {16'h0, count_b};
                default:              next_hrdata = 32'h0;
            endcase
        end
    end

    // ====================================================================
    // register writes; a rollover in the clearing cycle wins over the clear
    always_comb begin
        next_allow   = allow;
        next_clk_sel = clk_sel;
        next_mode    = mode;
        next_flags   = flags;
        if (wr_int) begin
            next_allow = hwdata[dei_pkg::INT_ALLOW_LSB +: 4];
            next_flags = flags & ~hwdata[dei_pkg::INT_FLAG_LSB +: 4];
        end
        if (wr_clk) begin
            next_clk_sel = hwdata[3:0];
        end
        if (wr_mode) begin
            next_mode = hwdata[15:0] & dei_pkg::MODE_WR_MASK;
        end
        next_flags = next_flags | rollover;
    end

    // interrupt level: any flag with its enable
    assign irq = |(flags & allow);

    // ====================================================================
    // sample clock sources: three-stage sync, edge once stages agree
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            next_src_lvl[i] = (src_s2[i] == src_s3[i]) ? src_s3[i] : src_lvl[i];
        end
    end

    // base tick divides the system clock down to 25 MHz
    assign next_div = (div == 2'(dei_pkg::BASE_TICK_DIV - 1)) ? 2'h0 : div + 2'h1;

    always_comb begin
        src_tick     = 16'h0;
        src_tick[0]  = (div == 2'(dei_pkg::BASE_TICK_DIV - 1));
        src_tick[dei_pkg::SEL_TC_LSB +: 6]   = next_src_lvl[5:0] & ~src_lvl[5:0];
        src_tick[dei_pkg::SEL_PROG_LSB +: 4] = next_src_lvl[9:6] & ~src_lvl[9:6];
        src_tick[dei_pkg::SEL_STRB_LSB +: 2] = next_src_lvl[11:10] & ~src_lvl[11:10];
        src_tick[dei_pkg::SEL_NSTRB_LSB +: 2] = ~next_src_lvl[11:10] & src_lvl[11:10];
    end

    // the reserved code leaves the position at zero, so nothing is sampled
    assign tick = src_tick[clk_sel];

    // ====================================================================
    // channel decoders
    assign if_a.tick                       = tick;
    assign if_a.pos_in                     = chan_a_pos_in;
    assign if_a.neg_in                     = chan_a_neg_in;
    assign if_a.transition_block_mask      = mode[dei_pkg::MODE_MASK_LSB +: 8];
    assign if_a.complementary_input_select = mode[dei_pkg::MODE_COMPL];
    assign if_a.glitch_on                  = mode[dei_pkg::MODE_GLITCH];
    assign if_b.tick                       = tick;
    assign if_b.pos_in                     = chan_b_pos_in;
    assign if_b.neg_in                     = chan_b_neg_in;
    assign if_b.transition_block_mask      = mode[dei_pkg::MODE_MASK_LSB +: 8];
    assign if_b.complementary_input_select = mode[dei_pkg::MODE_COMPL];
    assign if_b.glitch_on                  = mode[dei_pkg::MODE_GLITCH];

    dei_channel u_chan_a (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ch      (if_a.chan)
    );

    dei_channel u_chan_b (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ch      (if_b.chan)
    );

    // ====================================================================
    // counters; hold freezes them, in cascade B only moves on A's wrap
    assign run  = mode[dei_pkg::MODE_ACTIVE] && !mode[dei_pkg::MODE_HOLD];
    assign up_a = run && if_a.step_up;
    assign dn_a = run && if_a.step_down;

    always_comb begin
        rollover = 4'h0;
        rollover[dei_pkg::EVT_A_POS] = up_a && (count_a == dei_pkg::COUNT_MAX);
        rollover[dei_pkg::EVT_A_NEG] = dn_a && (count_a == dei_pkg::COUNT_MIN);
        if (mode[dei_pkg::MODE_CASCADE]) begin
            up_b = rollover[dei_pkg::EVT_A_POS];
            dn_b = rollover[dei_pkg::EVT_A_NEG];
        end else begin
            up_b = run && if_b.step_up;
            dn_b = run && if_b.step_down;
        end
        rollover[dei_pkg::EVT_B_POS] = up_b && (count_b == dei_pkg::COUNT_MAX);
        rollover[dei_pkg::EVT_B_NEG] = dn_b && (count_b == dei_pkg::COUNT_MIN);
        next_count_a = count_a;
        next_count_b = count_b;
        if (up_a) begin
            next_count_a = count_a + 16'h1;
        end else if (dn_a) begin
            next_count_a = count_a - 16'h1;
        end
        if (up_b) begin
            next_count_b = count_b + 16'h1;
        end else if (dn_b) begin
            next_count_b = count_b - 16'h1;
        end
    end

    // ====================================================================
    // state registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= BUS_IDLE;
            wr_addr   <= 8'h00;
            hrdata    <= 32'h0;
            flags     <= dei_pkg::RST_FLAGS;
            allow     <= dei_pkg::RST_ALLOW;
            clk_sel   <= dei_pkg::RST_CLK_SEL;
            mode      <= dei_pkg::RST_MODE;
            count_a   <= dei_pkg::RST_COUNT;
            count_b   <= dei_pkg::RST_COUNT;
            src_s1    <= 12'h0;
            src_s2    <= 12'h0;
            src_s3    <= 12'h0;
            src_lvl   <= 12'h0;
            div       <= 2'h0;
        end else begin
            bus_state <= next_bus_state;
            wr_addr   <= next_wr_addr;
            hrdata    <= next_hrdata;
            flags     <= next_flags;
            allow     <= next_allow;
            clk_sel   <= next_clk_sel;
            mode      <= next_mode;
            count_a   <= next_count_a;
            count_b   <= next_count_b;
            src_s1    <= {strobe, prog_clk, timer_tc};
            src_s2    <= src_s1;
            src_s3    <= src_s2;
            src_lvl   <= next_src_lvl;
            div       <= next_div;
        end
    end
endmodule : dei_top
`default_nettype wire

// *** verification/dei_top_props.sv ***
// concurrent checks on the dual encoder register block ports
`timescale 1ns/1ps
`default_nettype none
module dei_top_props (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        hreadyout,
    input  wire logic        hresp,
    // interrupt
    input  wire logic        irq
);
    // ====================================================================
    // transfer sequences
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_take(logic w);
        hsel && hready && htrans[1] && hwrite == w;
    endsequence
    sequence s_rd(logic [7:0] a);
        s_take(1'b0) ##0 haddr == a;
    endsequence
    // ====================================================================
    // properties
    property p_okay;
        hresp == 1'b0;
    endproperty
    property p_wr_wait;
        s_take(1'b1) |=> !hreadyout ##1 hreadyout;
    endproperty
    property p_rd_ready;
        s_take(1'b0) |=> hreadyout;
    endproperty
    property p_irq_reset;
        $rose(hresetn) |-> !irq;
    endproperty
    // the line only drops after a write commits, never on its own
    property p_irq_fall;
        $fell(irq) |-> !$past(hreadyout);
    endproperty
    property p_int_rsvd;
        s_rd(dei_pkg::OFS_INT) |=> hrdata[31:12] == 20'h0 && hrdata[7:4] == 4'h0;
    endproperty
    property p_clk_rsvd;
        s_rd(dei_pkg::OFS_CLK) |=> hrdata[31:4] == 28'h0;
    endproperty
    property p_mode_rsvd;
        s_rd(dei_pkg::OFS_MODE) |=> hrdata[31:16] == 16'h0 && hrdata[7:6] == 2'h0;
    endproperty
    // read data shows the registers of the cycle before, so compare with old irq
    property p_irq_match;
        s_rd(dei_pkg::OFS_INT) |=> (|(hrdata[11:8] & hrdata[3:0])) == $past(irq);
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    a_wr_wait: assert property (p_wr_wait) else $error("write wait state wrong");
    a_rd_ready: assert property (p_rd_ready) else $error("read not answered");
    a_irq_reset: assert property (p_irq_reset)
        else $error("irq high after reset");
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq fell without a write");
    a_int_rsvd: assert property (p_int_rsvd)
        else $error("interrupt reserved bits set");
    a_clk_rsvd: assert property (p_clk_rsvd)
        else $error("clock select upper bits set");
    a_mode_rsvd: assert property (p_mode_rsvd)
        else $error("mode reserved bits set");
    a_irq_match: assert property (p_irq_match)
        else $error("irq disagrees with flags and enables");
endmodule : dei_top_props
bind dei_top dei_top_props u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq));
`default_nettype wire

// *** verification/dei_encoder_model.sv ***
// quadrature shaft encoder model driving one channel's + and - pins
`timescale 1ns/1ps
`default_nettype none
module dei_encoder_model (
    // clock
    input  wire logic       hclk,
    // motion request: 1 forward, 2 backward, 0 still
    input  wire logic [1:0] dir,
    // encoder pins, {b, a}
    output logic [1:0]      pos_out,
    output logic [1:0]      neg_out
);
    logic [1:0] phase = 2'h0;
    logic [5:0] slow  = 6'h00;
    // ====================================================================
    // motion
    // one quarter step per 64 clocks keeps edges far apart for the glitch filter
    always @(posedge hclk) begin
        slow <= slow + 6'h01;
        if (slow == 6'h3f) begin
            phase <= phase + ((dir == 2'h1) ? 2'h1 : (dir == 2'h2) ? 2'h3 : 2'h0);
        end
    end
    // gray order 00,01,11,10 counts up; minus pins are true complements
    assign pos_out = {phase[1], phase[1] ^ phase[0]};
    assign neg_out = ~pos_out;
endmodule : dei_encoder_model
`default_nettype wire

// *** verification/test_dual_encoder_irq_clock_mode.sv ***
// self-checking bench of the dual encoder register block
`timescale 1ns/1ps
`default_nettype none
module test_dual_encoder_irq_clock_mode;
    typedef struct {logic [7:0] addr; logic [31:0] wdata; logic [31:0] exp;} dei_row_s;
    logic        hclk       = 1'b0;
    logic        hresetn    = 1'b0;
    logic        hsel       = 1'b1;
    logic [7:0]  haddr      = 8'h00;
    logic [1:0]  htrans     = 2'h0;
    logic        hwrite     = 1'b0;
    logic [31:0] hwdata     = 32'h0;
    logic [11:0] src        = 12'h000;
    logic [1:0]  a_dir      = 2'h0;
    logic [1:0]  b_dir      = 2'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic [1:0]  a_pos, a_neg, b_pos, b_neg;
    int          failures   = 0;
    int          n_compared = 0;
    dei_row_s    rows [6];
    // ====================================================================
    // clock, free-running sample sources and the design
    always #5 hclk = ~hclk;
    always @(posedge hclk) src <= src + 12'h001;
    dei_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .chan_a_pos_in(a_pos), .chan_a_neg_in(a_neg), .chan_b_pos_in(b_pos),
        .chan_b_neg_in(b_neg), .timer_tc(src[11:6]), .prog_clk(src[5:2]),
        .strobe(src[1:0]), .irq(irq));
    dei_encoder_model u_enc_a (.hclk(hclk), .dir(a_dir), .pos_out(a_pos), .neg_out(a_neg));
    dei_encoder_model u_enc_b (.hclk(hclk), .dir(b_dir), .pos_out(b_pos), .neg_out(b_neg));
    // ====================================================================
    // tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // single ahb-lite transfer; waits on hready in both phases, bounded
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 100);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 100);
        q = hrdata;
        if (n >= 100) failures++;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, exp, q);
    endtask : rd
    // one encoder quarter step, then room for sync and one sample tick
    task automatic step(input logic chan_b, input logic [1:0] d);
        logic [1:0] last;
        int         n;
        n     = 0;
        last  = chan_b ? b_pos : a_pos;
        a_dir <= chan_b ? 2'h0 : d;
        b_dir <= chan_b ? d : 2'h0;
        while ((chan_b ? b_pos : a_pos) === last && n < 200) begin
            @(posedge hclk);
            n++;
        end
        a_dir <= 2'h0;
        b_dir <= 2'h0;
        repeat (24) @(posedge hclk);
        if (n >= 200) failures++;
    endtask : step
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // ====================================================================
    // watchdog, far beyond the under one thousand clocks the tests need
    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        stop_test();
    end
    // ====================================================================
    // tests
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd("int", dei_pkg::OFS_INT, 32'h0);
        rd("clk", dei_pkg::OFS_CLK, 32'h0);
        rd("mode", dei_pkg::OFS_MODE, 32'h0);
        check("irq", 32'h0, {31'h0, irq});
        $display("test reset done");
        rows = '{'{dei_pkg::OFS_CLK, 32'hffff_fff5, 32'h5},
                 '{dei_pkg::OFS_MODE, 32'hffff_ffff, 32'hff3f},
                 '{dei_pkg::OFS_MODE, 32'h0, 32'h0},
                 '{dei_pkg::OFS_INT, 32'hffff_ffff, 32'h000f},
                 '{dei_pkg::OFS_COUNT_A, 32'hffff_ffff, 32'h0},
                 '{8'h14, 32'hffff_ffff, 32'h0}};
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd("row", rows[i].addr, rows[i].exp);
        end
        for (int c = 0; c < 16; c++) begin
            wr(dei_pkg::OFS_CLK, 32'(c));
            rd("clk code", dei_pkg::OFS_CLK, 32'(c));
        end
        wr(dei_pkg::OFS_CLK, {28'h0, dei_pkg::SEL_BASE_25M});
        $display("test registers done");
        wr(dei_pkg::OFS_MODE, 32'h8001);
        step(1'b0, 2'h2);
        rd("count a masked", dei_pkg::OFS_COUNT_A, 32'h0);
        step(1'b0, 2'h1);
        rd("count a", dei_pkg::OFS_COUNT_A, 32'h1);
        wr(dei_pkg::OFS_MODE, 32'h0001);
        step(1'b0, 2'h2);
        step(1'b0, 2'h2);
        rd("count a", dei_pkg::OFS_COUNT_A, 32'hffff);
        rd("int", dei_pkg::OFS_INT, 32'h020f);
        check("irq", 32'h1, {31'h0, irq});
        step(1'b0, 2'h1);
        rd("int", dei_pkg::OFS_INT, 32'h030f);
        step(1'b1, 2'h2);
        rd("int", dei_pkg::OFS_INT, 32'h0b0f);
        step(1'b1, 2'h1);
        rd("int", dei_pkg::OFS_INT, 32'h0f0f);
        $display("test rollover done");
        wr(dei_pkg::OFS_INT, 32'h0);
        rd("int", dei_pkg::OFS_INT, 32'h0f00);
        check("irq", 32'h0, {31'h0, irq});
        wr(dei_pkg::OFS_INT, 32'h0500);
        rd("int", dei_pkg::OFS_INT, 32'h0a00);
        wr(dei_pkg::OFS_INT, 32'h0a0f);
        rd("int", dei_pkg::OFS_INT, 32'h000f);
        check("irq", 32'h0, {31'h0, irq});
        wr(dei_pkg::OFS_MODE, 32'h0009);
        step(1'b0, 2'h2);
        rd("count b", dei_pkg::OFS_COUNT_B, 32'hffff);
        rd("int", dei_pkg::OFS_INT, 32'h0a0f);
        $display("test clear done");
        wr(dei_pkg::OFS_CLK, 32'h5);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd("clk", dei_pkg::OFS_CLK, 32'h0);
        rd("int", dei_pkg::OFS_INT, 32'h0);
        $display("test second reset done");
        stop_test();
    end
endmodule : test_dual_encoder_irq_clock_mode
`default_nettype wire
